// ---- src/eu_arch_consts.vh ----
// constants for the execution-unit special architectural registers
// assumes inclusion by bare name from the design file
`ifndef EU_ARCH_CONSTS_VH
`define EU_ARCH_CONSTS_VH
// register type encodings, regnum[7:4]
`define TYPE_NOTIFY 4'h9
`define TYPE_IP 4'ha
`define TYPE_TDEP 4'hb
`define TYPE_TIME 4'hc
// notification subregister numbers
`define SUB_NOTIFY_A 5'h00
`define SUB_NOTIFY_HOST 5'h04
`define SUB_NOTIFY_B 5'h08
// instruction pointer subregister number
`define SUB_IP 5'h00
// timestamp subregister numbers
`define SUB_TIME_LOW 5'h00
`define SUB_TIME_HIGH 5'h04
`define SUB_TIME_FLAG 5'h08
// field positions
`define CNT_MSB 15
`define DEP_VALID_BIT 15
`define DEP_ID_MSB 8
`define TDEP_SUB_STEP 2
`define DEP_WORD_W 16
`define IP_LOW_BITS 3
// reset values
`define ZERO32 32'h00000000
`define ZERO16 16'h0000
`define ZERO64 64'h0000000000000000
`define ONE64 64'h0000000000000001
`define ONE16 16'h0001
`define ZERO9 9'h000
`endif

// ---- src/eu_arch_special_registers.v ----
// special architectural register file of one execution-unit thread
// assumes a synchronous pipeline, dispatcher and broadcast network on clk_sys
//
// Notes on behaviour
// - three 32-bit notify registers, type 1001b
// - notify writes only during context restore
// - wait decrements nonzero notify count
// - wait on zero stalls until matching notification
// - notify cleared by reset, kept on dispatch
// - counts a and b: 16 bits, upper zero
// - host notify: one bit, set by host
// - 32-bit read-write instruction pointer, type 1010b
// - pointer reads current instruction, low bits zero
// - pointer write jumps, low three bits dropped
// - eight 16-bit dependency words, type 1011b
// - word: valid top, zeros, 9-bit thread id
// - dispatch loads words; end-of-thread clears valid
// - enabled write clears valid, keeps id
// - free-running 64-bit timestamp, two 32-bit halves
// - disruption event sets flag
// - whole timestamp read samples all together
// - save stores all; restore forces flag one
// - flag cleared on thread load and reads
`timescale 1ns/1ps
`default_nettype none
`include "eu_arch_consts.vh"
module eu_arch_special_registers #(
  parameter NUM_DEP = 8,
  parameter TID_W = 9
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] rd_type,
  input wire [4:0] rd_sub,
  input wire rd_en,
  input wire rd_whole_time,
  output reg [31:0] rd_data_ff,
  output reg [63:0] rd_time_ff,
  output reg rd_flag_ff,
  input wire [3:0] wr_type,
  input wire [4:0] wr_sub,
  input wire wr_en,
  input wire [31:0] wr_data,
  input wire ctx_restore,
  input wire ctx_save,
  output reg [95:0] save_time_ff,
  input wire wait_en,
  input wire [4:0] wait_sub,
  input wire [2:0] notify_in,
  output reg wait_stall_ff,
  input wire [31:0] cur_ip,
  output reg ip_jump_ff,
  output reg [31:0] ip_target_ff,
  input wire dispatch,
  input wire [31:0] dispatch_ip,
  input wire [NUM_DEP-1:0] dispatch_valid,
  input wire [NUM_DEP*TID_W-1:0] dispatch_ids,
  input wire eot_valid,
  input wire [TID_W-1:0] eot_id,
  input wire sendc_req,
  output reg sendc_hold_ff,
  input wire time_disrupt
);

  // ==============================================================
  // notification registers
  reg [15:0] notify_a_ff;
  reg notify_host_ff;
  reg [15:0] notify_b_ff;
  reg [15:0] nxt_notify_a;
  reg nxt_notify_host;
  reg [15:0] nxt_notify_b;
  wire wr_notify;
  wire wait_a;
  wire wait_h;
  wire wait_b;

  // direct writes only land while a restore runs
  assign wr_notify = wr_en && ctx_restore && (wr_type == `TYPE_NOTIFY);
  // wait targets, decoded per subregister
  assign wait_a = wait_en && (wait_sub == `SUB_NOTIFY_A);
  assign wait_h = wait_en && (wait_sub == `SUB_NOTIFY_HOST);
  assign wait_b = wait_en && (wait_sub == `SUB_NOTIFY_B);

  // count update: restore write, wait decrement, incoming notification
  always @* begin
    nxt_notify_a = notify_a_ff;
    nxt_notify_host = notify_host_ff;
    nxt_notify_b = notify_b_ff;
    if (wait_a && notify_a_ff != `ZERO16) begin
      nxt_notify_a = notify_a_ff - `ONE16;
    end
    if (wait_h && notify_host_ff) begin
      nxt_notify_host = 1'b0;
    end
    if (wait_b && notify_b_ff != `ZERO16) begin
      nxt_notify_b = notify_b_ff - `ONE16;
    end
    // a same-cycle consume and notification both apply to counts; the host bit ends set
    if (notify_in[0] && !(wait_a && notify_a_ff == `ZERO16)) begin
      nxt_notify_a = nxt_notify_a + `ONE16;
    end
    if (notify_in[1] && !(wait_h && !notify_host_ff)) begin
      nxt_notify_host = 1'b1;
    end
    if (notify_in[2] && !(wait_b && notify_b_ff == `ZERO16)) begin
      nxt_notify_b = nxt_notify_b + `ONE16;
    end
    if (wr_notify) begin
      case (wr_sub)
        `SUB_NOTIFY_A: nxt_notify_a = wr_data[`CNT_MSB:0];
        `SUB_NOTIFY_HOST: nxt_notify_host = wr_data[0];
        `SUB_NOTIFY_B: nxt_notify_b = wr_data[`CNT_MSB:0];
        default: nxt_notify_a = nxt_notify_a;
      endcase
    end
  end

  // notify state: cleared by reset, not by dispatch
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      notify_a_ff <= `ZERO16;
      notify_host_ff <= 1'b0;
      notify_b_ff <= `ZERO16;
    end else begin
      notify_a_ff <= nxt_notify_a;
      notify_host_ff <= nxt_notify_host;
      notify_b_ff <= nxt_notify_b;
    end
  end

  // stall when wait hits an empty register and no matching notification
  reg nxt_wait_stall;
  always @* begin
    nxt_wait_stall = 1'b0;
    if (wait_a && notify_a_ff == `ZERO16 && !notify_in[0]) begin
      nxt_wait_stall = 1'b1;
    end
    if (wait_h && !notify_host_ff && !notify_in[1]) begin
      nxt_wait_stall = 1'b1;
    end
    if (wait_b && notify_b_ff == `ZERO16 && !notify_in[2]) begin
      nxt_wait_stall = 1'b1;
    end
  end

  // registered stall pulse, one cycle per wait
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_stall_ff <= 1'b0;
    end else begin
      wait_stall_ff <= nxt_wait_stall;
    end
  end

  // ==============================================================
  // instruction pointer
  wire wr_ip;
  reg nxt_ip_jump;
  reg [31:0] nxt_ip_target;
  assign wr_ip = wr_en && (wr_type == `TYPE_IP) && (wr_sub == `SUB_IP);

  // jump request with low bits dropped; dispatch also loads a start ip
  always @* begin
    nxt_ip_jump = wr_ip || dispatch;
    nxt_ip_target = ip_target_ff;
    if (wr_ip) begin
      nxt_ip_target = {wr_data[31:`IP_LOW_BITS], 3'h0};
    end else if (dispatch) begin
      nxt_ip_target = {dispatch_ip[31:`IP_LOW_BITS], 3'h0};
    end
  end

  // jump pulse and target registers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ip_jump_ff <= 1'b0;
      ip_target_ff <= `ZERO32;
    end else begin
      ip_jump_ff <= nxt_ip_jump;
      ip_target_ff <= nxt_ip_target;
    end
  end

  // ==============================================================
  // thread dependency words
  wire [NUM_DEP-1:0] dep_valid;
  wire [NUM_DEP*`DEP_WORD_W-1:0] dep_words;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DEP; gi = gi + 1) begin : g_dep
      reg valid_ff;
      reg [TID_W-1:0] id_ff;
      reg nxt_valid;
      reg [TID_W-1:0] nxt_id;
      wire wr_hit;
      wire eot_hit;
      assign wr_hit = wr_en && (wr_type == `TYPE_TDEP) &&
                      (wr_sub == gi * `TDEP_SUB_STEP);
      assign eot_hit = eot_valid && (eot_id == id_ff);
      // valid and id load only at dispatch; retire or write clears valid
      always @* begin
        nxt_valid = valid_ff;
        nxt_id = id_ff;
        if (dispatch) begin
          nxt_valid = dispatch_valid[gi];
          nxt_id = dispatch_ids[gi*TID_W +: TID_W];
        end else if (wr_hit) begin
          nxt_valid = 1'b0;
        end else if (eot_hit) begin
          nxt_valid = 1'b0;
        end
      end
      // per-word state, one owner per flip-flop
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          valid_ff <= 1'b0;
          id_ff <= {TID_W{1'b0}};
        end else begin
          valid_ff <= nxt_valid;
          id_ff <= nxt_id;
        end
      end
      // read view: valid on top, reserved zeros, id at the bottom
      assign dep_valid[gi] = valid_ff;
      assign dep_words[gi*`DEP_WORD_W +: `DEP_WORD_W] =
        {valid_ff, {(`DEP_VALID_BIT-TID_W){1'b0}}, id_ff};
    end
  endgenerate

  // conditional send held while any dependency is in flight
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sendc_hold_ff <= 1'b0;
    end else begin
      sendc_hold_ff <= sendc_req && (|dep_valid);
    end
  end

  // ==============================================================
  // timestamp
  reg [63:0] time_ff;
  reg flag_ff;
  reg [63:0] nxt_time;
  reg nxt_flag;
  wire time_read;
  wire flag_restore;
  assign time_read = rd_en && (rd_type == `TYPE_TIME);
  assign flag_restore = ctx_restore && wr_en && (wr_type == `TYPE_TIME);

  // free-running count; disruption or restore beats a same-cycle read clear
  always @* begin
    nxt_time = time_ff + `ONE64;
    nxt_flag = flag_ff;
    if (time_disrupt || flag_restore) begin
      nxt_flag = 1'b1;
    end else if (dispatch || time_read) begin
      nxt_flag = 1'b0;
    end
  end

  // count and disruption flag registers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      time_ff <= `ZERO64;
      flag_ff <= 1'b0;
    end else begin
      time_ff <= nxt_time;
      flag_ff <= nxt_flag;
    end
  end

  // context save snapshot of the whole timestamp
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      save_time_ff <= {`ZERO64, `ZERO32};
    end else if (ctx_save) begin
      save_time_ff <= {31'h0, flag_ff, time_ff};
    end
  end

  // ==============================================================
  // read port
  reg [31:0] nxt_rd;
  reg [15:0] dep_word;
  integer k;
  always @* begin
    nxt_rd = `ZERO32;
    dep_word = `ZERO16;
    for (k = 0; k < NUM_DEP; k = k + 1) begin
      if (rd_sub == k * `TDEP_SUB_STEP) begin
        dep_word = dep_words[k*`DEP_WORD_W +: `DEP_WORD_W];
      end
    end
    case (rd_type)
      `TYPE_NOTIFY: begin
        case (rd_sub)
          `SUB_NOTIFY_A: nxt_rd = {16'h0000, notify_a_ff};
          `SUB_NOTIFY_HOST: nxt_rd = {31'h0, notify_host_ff};
          `SUB_NOTIFY_B: nxt_rd = {16'h0000, notify_b_ff};
          default: nxt_rd = `ZERO32;
        endcase
      end
      `TYPE_IP: begin
        if (rd_sub == `SUB_IP) begin
          nxt_rd = {cur_ip[31:`IP_LOW_BITS], 3'h0};
        end
      end
      `TYPE_TDEP: nxt_rd = {16'h0000, dep_word};
      `TYPE_TIME: begin
        case (rd_sub)
          `SUB_TIME_LOW: nxt_rd = time_ff[31:0];
          `SUB_TIME_HIGH: nxt_rd = time_ff[63:32];
          `SUB_TIME_FLAG: nxt_rd = {31'h0, flag_ff};
          default: nxt_rd = `ZERO32;
        endcase
      end
      default: nxt_rd = `ZERO32;
    endcase
  end

  // registered read data, held until the next read
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= `ZERO32;
    end else if (rd_en) begin
      rd_data_ff <= nxt_rd;
    end
  end

  // whole-time read samples count and flag at the same edge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_time_ff <= `ZERO64;
      rd_flag_ff <= 1'b0;
    end else if (rd_en && rd_whole_time) begin
      rd_time_ff <= time_ff;
      rd_flag_ff <= flag_ff;
    end
  end

endmodule
`default_nettype wire

// ---- tb/eu_arch_sva.sv ----
// checker for the special register file
// assumes binding onto every instance of the register file
`timescale 1ns/1ps
`default_nettype none
module eu_arch_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic [3:0] rd_type,
  input wire logic [4:0] rd_sub,
  input wire logic [31:0] rd_data_ff,
  input wire logic wr_en,
  input wire logic [3:0] wr_type,
  input wire logic [4:0] wr_sub,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] cur_ip,
  input wire logic dispatch,
  input wire logic ip_jump_ff,
  input wire logic [31:0] ip_target_ff,
  input wire logic sendc_req,
  input wire logic sendc_hold_ff,
  input wire logic time_disrupt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // =======
  // read decodes
  wire rn = rd_en && rd_type == 4'h9;
  wire rl = rd_en && rd_type == 4'hc && rd_sub == 5'h00;
  wire rf = rd_en && rd_type == 4'hc && rd_sub == 5'h08;
  property p_cnt_hi; rn |=> rd_data_ff[31:16] == 16'h0; endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count upper bits");
  property p_host; rn && rd_sub == 5'h04 |=> rd_data_ff[31:1] == 31'h0; endproperty
  a_host: assert property (p_host) else $error("host upper bits");
  property p_ip_rd; rd_en && rd_type == 4'ha && rd_sub == 5'h00
    |=> rd_data_ff == ($past(cur_ip) & 32'hfffffff8); endproperty
  a_ip_rd: assert property (p_ip_rd) else $error("pointer read");
  property p_ip_wr; wr_en && wr_type == 4'ha && wr_sub == 5'h00 && !dispatch
    |=> ip_jump_ff && ip_target_ff == ($past(wr_data) & 32'hfffffff8); endproperty
  a_ip_wr: assert property (p_ip_wr) else $error("pointer jump");
  property p_tdep; rd_en && rd_type == 4'hb |=> rd_data_ff[14:9] == 6'h0; endproperty
  a_tdep: assert property (p_tdep) else $error("dependency zeros");
  property p_time; rl ##1 rl |=> rd_data_ff == $past(rd_data_ff) + 32'h1; endproperty
  a_time: assert property (p_time) else $error("counter step");
  property p_flag; rf && !time_disrupt && !wr_en ##1 rf |=> rd_data_ff == 32'h0; endproperty
  a_flag: assert property (p_flag) else $error("flag not cleared");
  property p_sendc; sendc_hold_ff |-> $past(sendc_req); endproperty
  a_sendc: assert property (p_sendc) else $error("hold without send");
  c_hold: cover property (sendc_hold_ff);
  c_jump: cover property (ip_jump_ff);
  c_time: cover property (rl ##1 rl);
endmodule
bind eu_arch_special_registers eu_arch_sva eu_arch_sva_inst (.*);
`default_nettype wire

// ---- tb/eu_far_side.sv ----
// far-side model: end-of-thread broadcaster
// assumes one retire request at a time from the bench
`timescale 1ns/1ps
`default_nettype none
module eu_far_side (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic retire,
  input wire logic [8:0] retire_id,
  input wire logic [3:0] lat,
  output logic eot_valid,
  output logic [8:0] eot_id
);
  logic [3:0] cnt_ff;
  logic [8:0] id_ff;
  // broadcast after lat cycles; idle id line keeps toggling
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      id_ff <= 9'h000;
      eot_valid <= 1'b0;
      eot_id <= 9'h000;
    end else begin
      eot_valid <= cnt_ff == 4'h1;
      eot_id <= cnt_ff == 4'h1 ? id_ff : ~eot_id;
      if (retire) begin
        cnt_ff <= lat;
        id_ff <= retire_id;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the special register file
// assumes checker and far-side model compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 0, rst_n = 0, rd_en = 0, rd_whole_time = 0, wr_en = 0;
  logic ctx_restore = 0, ctx_save = 0, wait_en = 0, dispatch = 0, sendc_req = 0;
  logic time_disrupt = 0, retire = 0, rd_q_ff = 0;
  logic [3:0] rd_type = 0, wr_type = 0, lat = 0;
  logic [4:0] rd_sub = 0, wr_sub = 0, wait_sub = 0;
  logic [2:0] notify_in = 0;
  logic [31:0] wr_data = 0, cur_ip = 0, dispatch_ip = 0, rd_data_ff, ip_target_ff, rnd;
  logic [7:0] dispatch_valid = 0;
  logic [71:0] dispatch_ids = 0;
  logic [8:0] eot_id, retire_id = 0, ids [8];
  logic [63:0] rd_time_ff;
  logic [95:0] save_time_ff;
  logic [63:0] tcnt = 0;
  logic rd_flag_ff, wait_stall_ff, ip_jump_ff, sendc_hold_ff, eot_valid;
  logic [31:0] q [$];
  int failures = 0, checked = 0, i, k;
  eu_arch_special_registers eu_arch_special_registers_inst (.*);
  eu_far_side eu_far_side_inst (.*);
  always #10 clk_sys = ~clk_sys;
  // reference edge count since reset release
  always @(posedge clk_sys) if (rst_n) tcnt <= tcnt + 64'h1;
  // =======
  // read monitor: oldest note against each answer
  always @(posedge clk_sys) rd_q_ff <= rd_en;
  always @(negedge clk_sys) if (rd_q_ff && q.size() > 0) ck(rd_data_ff, q.pop_front());
  task cyc; @(posedge clk_sys); #1; endtask
  task ck(input logic [95:0] s, e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task rd(input logic [3:0] t, input logic [4:0] s, input logic [31:0] e);
    rd_type = t; rd_sub = s; rd_en = 1; q.push_back(e); cyc; rd_en = 0; cyc;
  endtask
  task wr(input logic [3:0] t, input logic [4:0] s, input logic [31:0] d);
    wr_type = t; wr_sub = s; wr_data = d; wr_en = 1; cyc; wr_en = 0;
  endtask
  task wt(input logic [4:0] s, input logic e, input logic [2:0] n);
    wait_sub = s; wait_en = 1; notify_in = n; cyc; wait_en = 0; notify_in = 0;
    ck(wait_stall_ff, e); cyc;
  endtask
  task summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // =======
  // main sequence
  initial begin
    rnd = $urandom(32'hf246a159);
    cyc; cyc; rst_n = 1; cyc;
    rd(4'h9, 5'h00, 32'h0);
    rd(4'h9, 5'h0c, 32'h0);
    notify_in = 3'h7; cyc; cyc; notify_in = 0; cyc;
    rd(4'h9, 5'h00, 32'h2);
    rd(4'h9, 5'h04, 32'h1);
    wr(4'h9, 5'h08, 32'h9); cyc;
    rd(4'h9, 5'h08, 32'h2);
    ctx_restore = 1; wr(4'h9, 5'h08, 32'hffff0005); ctx_restore = 0; cyc;
    rd(4'h9, 5'h08, 32'h5);
    wt(5'h08, 0, 3'h0); rd(4'h9, 5'h08, 32'h4);
    wt(5'h04, 0, 3'h0); wt(5'h04, 1, 3'h0);
    wt(5'h04, 0, 3'h2);
    rd(4'h9, 5'h04, 32'h0);
    dispatch = 1; cyc; dispatch = 0; cyc;
    rd(4'h9, 5'h08, 32'h4);
    $display("notify test done");
    rnd = $urandom; cur_ip = rnd; rd(4'ha, 5'h00, rnd & 32'hfffffff8);
    rd(4'ha, 5'h04, 32'h0);
    rnd = $urandom; wr(4'ha, 5'h00, rnd);
    ck(ip_jump_ff, 1);
    ck(ip_target_ff, rnd & 32'hfffffff8); cyc;
    $display("pointer test done");
    for (k = 0; k < 8; k++) begin
      rnd = $urandom; ids[k] = {rnd[5:0], k[2:0]}; dispatch_ids[9*k+:9] = ids[k];
    end
    dispatch_valid = 8'hff; dispatch = 1; cyc; dispatch = 0; cyc;
    for (k = 0; k < 8; k++) rd(4'hb, 5'(2*k), {7'h40, ids[k]});
    sendc_req = 1; cyc; ck(sendc_hold_ff, 1);
    wr(4'hb, 5'h00, 32'hffff); cyc;
    rd(4'hb, 5'h00, {23'h0, ids[0]});
    for (k = 1; k < 8; k++) begin
      retire_id = ids[k]; lat = k[3:0]; retire = 1; cyc; retire = 0;
      for (i = 0; i < 20 && eot_valid !== 1'b1; i++) cyc;
      if (i == 20) begin failures++; summarize; end
      cyc;
    end
    cyc; ck(sendc_hold_ff, 0); sendc_req = 0;
    rd(4'hb, 5'h0e, {23'h0, ids[7]});
    $display("dependency test done");
    time_disrupt = 1; cyc; time_disrupt = 0;
    rd(4'hc, 5'h08, 32'h1);
    rd(4'hc, 5'h08, 32'h0);
    rd(4'hc, 5'h04, 32'h0);
    time_disrupt = 1; cyc; time_disrupt = 0;
    rd_whole_time = 1; rd_type = 4'hc; rd_sub = 5'h00; rd_en = 1; cyc;
    ck(rd_flag_ff, 1);
    ck(rd_time_ff, tcnt - 64'h1);
    ck(rd_time_ff[63:32], 32'h0); cyc; rd_en = 0; rd_whole_time = 0;
    ck(rd_flag_ff, 0);
    ctx_restore = 1; wr(4'hc, 5'h08, 32'h0); ctx_restore = 0; cyc;
    ctx_save = 1; cyc; ctx_save = 0;
    ck(save_time_ff[63:0], tcnt - 64'h1); cyc;
    ck(save_time_ff[95:64], 32'h1);
    dispatch = 1; cyc; dispatch = 0; cyc;
    rd(4'hc, 5'h08, 32'h0);
    time_disrupt = 1; cyc; time_disrupt = 0; q.push_back(32'h1); q.push_back(32'h0);
    rd_type = 4'hc; rd_sub = 5'h08; rd_en = 1; cyc; cyc; rd_en = 0; cyc;
    $display("timestamp test done");
    summarize;
  end
endmodule
`default_nettype wire
